/* File: design/mfir_filter.sv */
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Engines = multiplies over floored clocks, rounded up
// - Uneven split fills spare slots with zeros
// - Symmetric impulse response starts with padded zero outputs
// - Systolic mode is pipelined direct form, folds
// - Transposed mode: no accumulator, lower latency, unfolded
// - Symmetric taps pre-add sample pairs, halving multiplies
// - Negative symmetry subtracts pairs before multiply
// - Leading pads only when cycles go unused
// - Four cycles, 30 taps: one zero each end
// - Non-symmetric structure pads trailing zeros only
// - Single rate: one output per input
// - Systolic half-band skips interleaved zero taps
module mfir_filter
  import mfir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid_i,
  input wire logic [DW-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [AW-1:0] out_data_o,
  input wire logic out_ready_i
);

  // State of the filter outside the engines
  typedef struct packed {
    mfir_fsm_t st;                           // Sequencer
    logic [CCW-1:0] cyc;                     // Cycle within sample
    logic trans;                             // Transposed structure
    logic [1:0] sym;                         // Symmetry code
    logic hb;                                // Half-band type
    logic [TIW-1:0] ntaps;                   // Specified taps
    logic [KW-1:0] caddr;                    // Coefficient pointer
    logic [TAPS_MAX-1:0][CW-1:0] coef;       // Raw coefficients
    logic [TAPS_MAX-1:0][DW-1:0] dline;      // Sample history
    logic [TAPS_MAX-1:0][AW-1:0] psum;       // Transposed partial sums
    logic [AW-1:0] odata;                    // Output sample
    logic ovalid;                            // Output pending
    logic ack;                               // Bus answer
    logic [31:0] rdat;                       // Bus read data
  } mfir_core_t;

  localparam mfir_core_t CORE_RST = '{
    st: ST_IDLE,
    ntaps: NTAPS_RST,
    default: '0
  };

  mfir_core_t r_q;
  mfir_core_t r_d;
  mfir_cfg_t cfg;                            // Derived schedule
  mfir_slot_t sl [MAC_NUM];                  // Per-engine slot
  logic [DW-1:0] eng_a [MAC_NUM];            // Engine sample
  logic [DW-1:0] eng_b [MAC_NUM];            // Engine pair sample
  logic [CW-1:0] eng_c [MAC_NUM];            // Engine coefficient
  logic [PW-1:0] eng_p [MAC_NUM];            // Engine product
  logic [AW-1:0] eng_acc [MAC_NUM];          // Engine sum
  logic [AW-1:0] psum_new [MAC_NUM];         // Next partial sums
  logic eng_en;                              // Systolic accumulate
  logic eng_first;                           // First slot of sample
  logic eng_neg;                             // Subtract pairs
  logic in_ready;                            // Sample accept
  logic wb_req;                              // New bus request
  logic [31:0] ctrl_view;                    // Control readback
  logic [31:0] w;                            // Merged write word
  logic [AW-1:0] tot;                        // Engine total

  // Byte-lane merge of a write
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Map a slot number to taps
  function automatic mfir_slot_t slot_map(input int s,
                                          input mfir_cfg_t c,
                                          input logic [TIW-1:0] n,
                                          input logic [1:0] sym,
                                          input logic hb,
                                          input logic trans);
    mfir_slot_t r;
    int half;
    int ctr;
    int pk;
    int odd0;
    int cnt;
    r = '0;
    half = (int'(n) + 1) / 2;
    ctr = (int'(n) - 1) / 2;
    // Live side taps sit an odd distance from the centre
    odd0 = ((ctr % 2) == 0) ? 1 : 0;
    cnt = half - odd0;
    if (hb && !trans) begin
      // Live side taps first, centre tap last
      if (s < cnt) begin
        r.ok = 1'b1;
        r.k = KW'(2 * s + odd0);
      end else if (s == cnt) begin
        r.ok = 1'b1;
        r.k = KW'(ctr);
      end
    end else if (sym != SYM_NONE && !trans) begin
      // Fold tap k with its mirror
      pk = int'(c.plen) - 1 - s;
      r.ok = (s < int'(c.slots));
      r.k = KW'(s);
      r.pk = KW'(pk);
      r.pair = r.ok && (pk != s);
    end else begin
      r.ok = (s < int'(c.plen));
      r.k = KW'(s);
    end
    return r;
  endfunction

  // Padded coefficient at tap k
  function automatic logic [CW-1:0] coef_at(input logic [KW-1:0] k,
                                            input mfir_cfg_t c,
                                            input logic [TIW-1:0] n,
                                            input logic [TAPS_MAX-1:0][CW-1:0] tab);
    int i;
    i = int'(k) - int'(c.lead);
    // Pads ahead of and after the taps read zero
    if (i >= 0 && i < int'(n)) begin
      return tab[i];
    end
    return '0;
  endfunction

  // Engine inputs for this cycle
  always_comb begin
    cfg = mfir_cfg_calc(r_q.ntaps, r_q.sym, r_q.hb, r_q.trans);
    eng_en = (r_q.st == ST_RUN) && !r_q.trans;
    eng_first = (r_q.cyc == '0);
    eng_neg = (r_q.sym == SYM_NEG) && !r_q.trans;
    // Slots past the schedule get a zero coefficient
    for (int m = 0; m < MAC_NUM; m++) begin
      // Consecutive slots per cycle keep the partial-sum chain in order
      sl[m] = slot_map(int'(r_q.cyc) * MAC_NUM + m, cfg, r_q.ntaps,
                       r_q.sym, r_q.hb, r_q.trans);
      if (r_q.trans) begin
        eng_a[m] = r_q.dline[0];
      end else begin
        eng_a[m] = r_q.dline[sl[m].k];
      end
      eng_b[m] = sl[m].pair ? r_q.dline[sl[m].pk] : '0;
      eng_c[m] = sl[m].ok ? coef_at(sl[m].k, cfg, r_q.ntaps, r_q.coef) : '0;
    end
  end

  // Shared multiply engines
  for (genvar m = 0; m < MAC_NUM; m++) begin : g_eng
    mfir_mac_engine u_eng (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(eng_en),
      .first_i(eng_first),
      .neg_i(eng_neg),
      .a_i(eng_a[m]),
      .b_i(eng_b[m]),
      .coef_i(eng_c[m]),
      .prod_o(eng_p[m]),
      .acc_o(eng_acc[m])
    );
  end

  // Transposed chain and systolic total
  always_comb begin
    tot = '0;
    for (int m = 0; m < MAC_NUM; m++) begin
      // Next partial sum: older sum plus new product
      if (int'(sl[m].k) + 1 < int'(cfg.plen)) begin
        psum_new[m] = r_q.psum[int'(sl[m].k) + 1]
                      + {{(AW - PW){eng_p[m][PW-1]}}, eng_p[m]};
      end else begin
        psum_new[m] = {{(AW - PW){eng_p[m][PW-1]}}, eng_p[m]};
      end
      tot = tot + eng_acc[m];
    end
  end

  // Control register view
  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_TRANS] = r_q.trans;
    ctrl_view[CTRL_SYM +: 2] = r_q.sym;
    ctrl_view[CTRL_HB] = r_q.hb;
  end

  // Accept only when idle and output drained
  // A pending result blocks the next take, so set and clear never meet
  assign in_ready = (r_q.st == ST_IDLE) && !r_q.ovalid;

  // Next state
  always_comb begin
    r_d = r_q;
    w = '0;
    r_d.ack = 1'b0;
    wb_req = wb_cyc_i && wb_stb_i && !r_q.ack;
    // Register access, answered one cycle later
    if (wb_req) begin
      r_d.ack = 1'b1;
      r_d.rdat = '0;
      case (wb_adr_i)
        REG_CTRL: begin
          r_d.rdat = ctrl_view;
          if (wb_we_i) begin
            w = wb_merge(ctrl_view, wb_dat_i, wb_sel_i);
            r_d.trans = w[CTRL_TRANS];
            r_d.sym = w[CTRL_SYM +: 2];
            r_d.hb = w[CTRL_HB];
          end
        end
        REG_NTAPS: begin
          r_d.rdat[TIW-1:0] = r_q.ntaps;
          if (wb_we_i) begin
            w = wb_merge({26'h0000000, r_q.ntaps}, wb_dat_i, wb_sel_i);
            // Clamp to the supported range
            if (w < 32'(TAPS_MIN)) begin
              r_d.ntaps = TIW'(TAPS_MIN);
            end else if (w > 32'(TAPS_MAX)) begin
              r_d.ntaps = TIW'(TAPS_MAX);
            end else begin
              r_d.ntaps = w[TIW-1:0];
            end
          end
        end
        REG_CADDR: begin
          r_d.rdat[KW-1:0] = r_q.caddr;
          if (wb_we_i) begin
            w = wb_merge({27'h0000000, r_q.caddr}, wb_dat_i, wb_sel_i);
            r_d.caddr = w[KW-1:0];
          end
        end
        REG_CDATA: begin
          r_d.rdat[CW-1:0] = r_q.coef[r_q.caddr];
          if (wb_we_i) begin
            // Every tap is loaded, zero taps too
            w = wb_merge({16'h0000, r_q.coef[r_q.caddr]}, wb_dat_i, wb_sel_i);
            r_d.coef[r_q.caddr] = w[CW-1:0];
            r_d.caddr = r_q.caddr + 1'b1;
          end
        end
        REG_STATUS: begin
          r_d.rdat[STS_MACS +: MW] = cfg.macs;
          r_d.rdat[STS_PLEN +: TIW] = cfg.plen;
          r_d.rdat[STS_LEAD +: TIW] = cfg.lead;
          r_d.rdat[STS_BUSY] = (r_q.st != ST_IDLE);
        end
        REG_LAT: begin
          r_d.rdat = r_q.trans ? 32'(LAT_TRANS) : 32'(LAT_SYS);
        end
        default: begin
          r_d.rdat = '0;
        end
      endcase
    end
    // Downstream takes the sample
    if (r_q.ovalid && out_ready_i) begin
      r_d.ovalid = 1'b0;
    end
    // Sample sequencer, fixed cycle count
    case (r_q.st)
      ST_IDLE: begin
        if (in_valid_i && in_ready) begin
          r_d.dline = {r_q.dline[TAPS_MAX-2:0], in_data_i};
          r_d.cyc = '0;
          r_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (r_q.trans) begin
          // Update every scheduled partial sum
          // Reads see the last sample's sums, as tap k+1 is never updated in an earlier cycle than tap k
          for (int m = 0; m < MAC_NUM; m++) begin
            if (sl[m].ok) begin
              r_d.psum[sl[m].k] = psum_new[m];
            end
          end
          // Head of the chain is ready at once
          if (r_q.cyc == '0) begin
            r_d.odata = psum_new[0];
            r_d.ovalid = 1'b1;
          end
        end
        if (r_q.cyc == CCW'(CPS - 1)) begin
          r_d.st = r_q.trans ? ST_IDLE : ST_SUM;
        end else begin
          r_d.cyc = r_q.cyc + 1'b1;
        end
      end
      ST_SUM: begin
        // Add the engine sums
        r_d.odata = tot;
        r_d.ovalid = 1'b1;
        r_d.st = ST_IDLE;
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= CORE_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign wb_dat_o = r_q.rdat;
  assign wb_ack_o = r_q.ack;
  assign in_ready_o = in_ready;
  assign out_valid_o = r_q.ovalid;
  assign out_data_o = r_q.odata;

endmodule
`default_nettype wire

/* File: design/mfir_mac_engine.sv */
`timescale 1ns/100ps
`default_nettype none
module mfir_mac_engine
  import mfir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic first_i,
  input wire logic neg_i,
  input wire logic [DW-1:0] a_i,
  input wire logic [DW-1:0] b_i,
  input wire logic [CW-1:0] coef_i,
  output logic [PW-1:0] prod_o,
  output logic [AW-1:0] acc_o
);

  // Engine state
  typedef struct packed {
    logic [AW-1:0] acc;
  } mfir_eng_t;

  mfir_eng_t s_q;
  mfir_eng_t s_d;
  logic signed [DW:0] pre;     // Folded sample pair
  logic signed [PW-1:0] prod;  // Pre-add times coefficient

  // Pre-combine, multiply, accumulate
  always_comb begin
    if (neg_i) begin
      pre = $signed({a_i[DW-1], a_i}) - $signed({b_i[DW-1], b_i});
    end else begin
      pre = $signed({a_i[DW-1], a_i}) + $signed({b_i[DW-1], b_i});
    end
    prod = $signed({{CW{pre[DW]}}, pre}) * $signed({{(DW + 1){coef_i[CW-1]}}, coef_i});
    s_d = s_q;
    if (en_i) begin
      // First slot restarts the sum
      if (first_i) begin
        s_d.acc = {{(AW - PW){prod[PW-1]}}, prod};
      end else begin
        s_d.acc = s_q.acc + {{(AW - PW){prod[PW-1]}}, prod};
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prod_o = prod;
  assign acc_o = s_q.acc;

endmodule
`default_nettype wire

/* File: design/mfir_pkg.sv */
package mfir_pkg;

  // Datapath widths
  localparam int DW = 16;               // Input sample width
  localparam int CW = 16;               // Coefficient width
  localparam int PW = DW + 1 + CW;      // Pre-added sample times coefficient
  localparam int AW = 40;               // Accumulator and output width
  localparam int TAPS_MAX = 32;         // Largest padded coefficient vector
  localparam int TAPS_MIN = 2;          // Smallest accepted tap count
  localparam int TIW = 6;               // Tap count width
  localparam int KW = 5;                // Tap index width
  localparam int MW = 4;                // Engine count width

  // Rates: clocks per sample rounds down
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_HZ = 5_000_000;
  localparam int CPS = CLK_HZ / SAMPLE_HZ;
  localparam int CCW = $clog2(CPS);
  // Engines for the worst case, rounded up
  localparam int MAC_NUM = (TAPS_MAX + CPS - 1) / CPS;

  // Input-to-output latency in clock edges
  localparam int LAT_TRANS = 2;
  localparam int LAT_SYS = CPS + 2;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NTAPS = 8'h04;
  localparam logic [7:0] REG_CADDR = 8'h08;
  localparam logic [7:0] REG_CDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LAT = 8'h14;

  // Field positions
  localparam int CTRL_TRANS = 0;
  localparam int CTRL_SYM = 1;
  localparam int CTRL_HB = 3;
  localparam int STS_MACS = 0;
  localparam int STS_PLEN = 8;
  localparam int STS_LEAD = 16;
  localparam int STS_BUSY = 24;

  // Reset values
  localparam logic [TIW-1:0] NTAPS_RST = 6'h1E;

  // Symmetry codes
  localparam logic [1:0] SYM_NONE = 2'h0;
  localparam logic [1:0] SYM_POS = 2'h1;
  localparam logic [1:0] SYM_NEG = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_SUM = 3'b100
  } mfir_fsm_t;

  // Derived schedule of one configuration
  typedef struct packed {
    logic [MW-1:0] macs;
    logic [TIW-1:0] plen;
    logic [TIW-1:0] lead;
    logic [TIW-1:0] slots;
  } mfir_cfg_t;

  // One engine's work in one cycle
  typedef struct packed {
    logic ok;
    logic [KW-1:0] k;
    logic [KW-1:0] pk;
    logic pair;
  } mfir_slot_t;

  function automatic int mfir_ceil_div(input int a, input int b);
    return (a + b - 1) / b;
  endfunction

  // Engine count, padded length and leading pad
  function automatic mfir_cfg_t mfir_cfg_calc(input logic [TIW-1:0] ntaps,
                                              input logic [1:0] sym,
                                              input logic hb,
                                              input logic trans);
    int n;
    int macs;
    int slots;
    int plen;
    int lead;
    mfir_cfg_t c;
    n = int'(ntaps);
    lead = 0;
    if (hb && !trans) begin
      slots = (n + 1) / 2 + (((n - 1) / 2) % 2);
      macs = mfir_ceil_div(slots, CPS);
      plen = n;
    end else if (sym != SYM_NONE && !trans) begin
      macs = mfir_ceil_div((n + 1) / 2, CPS);
      slots = macs * CPS;
      plen = (n % 2 == 1) ? 2 * slots - 1 : 2 * slots;
      lead = (plen - n) / 2;
    end else begin
      macs = mfir_ceil_div(n, CPS);
      plen = macs * CPS;
      slots = plen;
    end
    c.macs = MW'(macs);
    c.plen = TIW'(plen);
    c.lead = TIW'(lead);
    c.slots = TIW'(slots);
    return c;
  endfunction

endpackage

/* File: sim/mfir_filter_props.sv */
`timescale 1ns/100ps
`default_nettype none
module mfir_filter_props
  import mfir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic in_valid_i,
  input wire logic in_ready_o,
  input wire logic out_valid_o,
  input wire logic [AW-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic trans_q; // Structure bit as last written
  logic take; // Sample accepted this cycle
  logic ctrl_wr; // Control write taken this cycle
  assign take = in_valid_i & in_ready_o;
  assign ctrl_wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  // Shadow of the structure select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trans_q <= 1'b0;
    end else if (ctrl_wr) begin
      trans_q <= wb_dat_i[CTRL_TRANS];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Answer windows of the two structures
  sequence s_sys_answer;
    (!out_valid_o)[*5] ##1 out_valid_o;
  endsequence
  sequence s_trn_answer;
    !out_valid_o ##1 out_valid_o;
  endsequence
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  a_sys_latency: assert property (take && !trans_q |=> s_sys_answer)
    else $error("systolic result not on time");
  a_trn_latency: assert property (take && trans_q |=> s_trn_answer)
    else $error("transposed result not on time");
  a_busy_run: assert property (take |=> (!in_ready_o)[*4])
    else $error("sample accepted while computing");
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("result dropped or changed while stalled");
  a_out_once: assert property (out_valid_o && out_ready_i |=> !out_valid_o)
    else $error("result delivered twice");
  a_no_overrun: assert property (out_valid_o |-> !in_ready_o)
    else $error("input open while result pending");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !out_valid_o && in_ready_o)
    else $error("reset state wrong");
endmodule
bind mfir_filter mfir_filter_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));
`default_nettype wire

/* File: sim/mfir_filter_test.sv */
`timescale 1ns/100ps
`default_nettype none
module mfir_filter_test
  import mfir_pkg::*;
;
  localparam int NS = 40; // Samples per configuration
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, in_valid_i, in_ready_o, out_valid_o, out_ready_i;
  logic stall = 1'b0;
  logic [DW-1:0] in_data_i;
  logic [AW-1:0] out_data_o;
  int fail_count = 0, comparisons = 0;
  longint xs[$]; // Model input history
  logic [31:0] q;
  mfir_filter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_ready_i(out_ready_i));
  mfir_stream_peer peer (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .in_ready_i(in_ready_o),
    .in_valid_o(in_valid_i), .in_data_o(in_data_i), .out_valid_i(out_valid_o),
    .out_data_i(out_data_o), .out_ready_o(out_ready_i));
  initial forever #25 clk_i = ~clk_i;
  // Random downstream stalls
  always @(posedge clk_i) stall <= ($urandom_range(0, 2) == 0);
  task automatic check(input logic [AW-1:0] seen, input logic [AW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic bus cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rd);
    logic got;
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    got = 1'b0;
    n = 0;
    while (!got && n < 50) begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
      rd = wb_dat_o;
      n++;
    end
    if (!got) begin
      fail_count++;
      $display("Error at %0t: bus acknowledge missing", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    xs.delete();
    peer.tx_q.delete();
    peer.rx_q.delete();
    @(posedge clk_i);
  endtask
  // Configure, stream NS samples, compare against the convolution model
  task automatic run_cfg(input logic trans, input logic [1:0] sym, input logic hb, input int n);
    int lead, plen, macs, slots, k, i, w;
    longint cf[TAPS_MAX];
    longint y;
    logic [CW-1:0] c;
    logic [DW-1:0] s;
    logic [16:0] e;
    do_reset();
    wb(1'b1, REG_NTAPS, 32'(n), q);
    wb(1'b1, REG_CTRL, {28'h0, hb, sym, trans}, q);
    wb(1'b1, REG_CADDR, 32'h0, q);
    for (k = 0; k < n; k++) begin
      c = CW'($urandom);
      cf[k] = $signed(c) / 2;
      if (2 * k > n - 1) cf[k] = (sym == SYM_NEG) ? -cf[n - 1 - k] : cf[n - 1 - k];
      else if (hb && 2 * k != n - 1 && ((n - 1) / 2 - k) % 2 == 0) cf[k] = 0;
      else if (sym == SYM_NEG && 2 * k == n - 1) cf[k] = 0;
      wb(1'b1, REG_CDATA, 32'(cf[k][CW-1:0]), q);
    end
    lead = 0;
    macs = (n + 3) / 4;
    plen = macs * 4;
    if (hb && !trans) begin
      slots = (n + 1) / 2 + ((n - 1) / 2) % 2;
      macs = (slots + 3) / 4;
      plen = n;
    end else if (sym != SYM_NONE && !trans) begin
      macs = ((n + 1) / 2 + 3) / 4;
      plen = 8 * macs - n % 2;
      lead = (plen - n) / 2;
    end
    e = {1'b0, 6'(lead), 6'(plen), 4'(macs)};
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(AW'({q[24], q[21:16], q[13:8], q[3:0]}), AW'(e));
    wb(1'b0, REG_LAT, 32'h0, q);
    check(AW'(q), AW'(trans ? LAT_TRANS : LAT_SYS));
    for (i = 0; i < NS; i++) begin
      s = (i == 0) ? DW'(1) : DW'($urandom);
      xs.push_back($signed(s));
      peer.tx_q.push_back(s);
    end
    w = 0;
    while (peer.rx_q.size() < NS && w < 3000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (20) @(posedge clk_i);
    check(AW'(peer.rx_q.size()), AW'(NS));
    if (lead > 0) check(peer.rx_q[0], '0);
    for (i = 0; i < NS; i++) begin
      y = 0;
      for (k = lead; k < lead + n; k++) if (i >= k) y += cf[k - lead] * xs[i - k];
      check(peer.rx_q[i], AW'(y));
    end
  endtask
  task automatic tally_and_finish();
    $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #(50 * 60000);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // Main sequence
  initial begin
    void'($urandom(41083));
    do_reset();
    wb(1'b0, REG_NTAPS, 32'h0, q);
    check(AW'(q), AW'(NTAPS_RST));
    wb(1'b1, REG_NTAPS, 32'h1, q);
    wb(1'b0, REG_NTAPS, 32'h0, q);
    check(AW'(q), AW'(TAPS_MIN));
    wb(1'b0, 8'h1C, 32'h0, q);
    check(AW'(q), '0);
    run_cfg(1'b0, SYM_NONE, 1'b0, 30);
    run_cfg(1'b0, SYM_POS, 1'b0, 30);
    run_cfg(1'b0, SYM_NEG, 1'b0, 29);
    run_cfg(1'b0, SYM_POS, 1'b0, 32);
    run_cfg(1'b1, SYM_POS, 1'b0, 13);
    run_cfg(1'b0, SYM_NONE, 1'b1, 11);
    run_cfg(1'b0, SYM_NONE, 1'b1, 9);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: sim/mfir_stream_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module mfir_stream_peer
  import mfir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic in_ready_i,
  output logic in_valid_o,
  output logic [DW-1:0] in_data_o,
  input wire logic out_valid_i,
  input wire logic [AW-1:0] out_data_i,
  output logic out_ready_o
);
  logic [DW-1:0] tx_q[$]; // Samples still to send
  logic [AW-1:0] rx_q[$]; // Results caught
  logic rdy_s, ov_s, stall_s; // Settled values before the edge
  logic [AW-1:0] od_s;
  initial begin
    in_valid_o = 1'b0;
    in_data_o = '0;
    out_ready_o = 1'b0;
  end
  // Snapshot design outputs away from the sampling edge
  always @(negedge clk_i) begin
    rdy_s = in_ready_i;
    ov_s = out_valid_i;
    od_s = out_data_i;
    stall_s = stall_i;
  end
  // Source holds each sample until taken, sink stalls on demand
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_valid_o <= 1'b0;
      out_ready_o <= 1'b0;
    end else begin
      if (in_valid_o && rdy_s) void'(tx_q.pop_front());
      if (tx_q.size() != 0) begin
        in_valid_o <= 1'b1;
        in_data_o <= tx_q[0];
      end else begin
        in_valid_o <= 1'b0;
        in_data_o <= ~in_data_o; // Idle data keeps moving
      end
      if (ov_s && out_ready_o) rx_q.push_back(od_s);
      out_ready_o <= !stall_s;
    end
  end
endmodule
`default_nettype wire
